// ---- dv/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        clkOut;
    logic        clkOe;
    logic        fsOut;
    logic        fsOe;
    logic        txData;
    logic        txOe;
    logic        rxData;
    logic        codecClk;
    logic        codecFs;
    logic        codecRun;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  divs [3];
    int          mismatches;
    int          samplesChecked;
    thc_highway dut_u (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .highwayClockIn(clkOe ? clkOut : codecClk),
        .highwayClockOut(clkOut), .highwayClockOe(clkOe), .frameSyncIn(fsOe ? fsOut : codecFs),
        .frameSyncOut(fsOut), .frameSyncOe(fsOe), .rxDataIn(rxData), .txDataOut(txData),
        .txDataOe(txOe), .dmaReq(), .dmaAck(1'h0), .dmaRdata(32'h0));
    thc_codec_model codec_u (.run(codecRun), .txData(txData), .txOe(txOe), .pinClk(codecClk),
        .fsync(codecFs), .rxData(rxData));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        // Answer is read mid-cycle, where it has settled, then taken at the edge
        @(negedge clock);
        while (pready !== 1'h1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        rd = prdata;
        err = pslverr;
        @(posedge clock);
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask
    // Skip the lag of the registered level before polling
    task automatic wait_irq();
        int n;
        n = 0;
        repeat (3) @(posedge clock);
        while (irq !== 1'h1 && n < 6000) begin
            @(posedge clock);
            n++;
        end
        if (irq !== 1'h1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    initial begin
        reset_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        codecRun = 1'h0;
        mismatches = 0;
        samplesChecked = 0;
        divs = '{8'h01, 8'h02, 8'hFE};
        repeat (5) @(posedge clock);
        reset_n <= 1'h1;
        rdc(thc_pkg::ADDR_CLOCK_CTRL, 32'h100);
        rdc(thc_pkg::ADDR_HOLDING, 32'h0);
        apb(1'h1, thc_pkg::ADDR_TX_BASE, 32'hFFFF_FFFF);
        rdc(thc_pkg::ADDR_TX_BASE, 32'h0);
        rdc(16'hA804, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'h1, thc_pkg::ADDR_CONTROL, 32'h8);
        foreach (divs[i]) begin
            apb(1'h1, thc_pkg::ADDR_CLOCK_CTRL, {22'h0, 2'h3, divs[i]});
            repeat (600) @(posedge clock);
            rdc(thc_pkg::ADDR_CLOCK_CTRL, {22'h0, 2'h3, divs[i]});
        end
        check({31'h0, clkOe}, 32'h1);
        apb(1'h1, thc_pkg::ADDR_CLOCK_CTRL, 32'h200);
        repeat (4) @(posedge clock);
        rd = {31'h0, clkOut};
        repeat (300) @(posedge clock);
        check({31'h0, clkOut}, rd);
        apb(1'h1, thc_pkg::ADDR_CONTROL, 32'h0);
        apb(1'h1, thc_pkg::ADDR_CLOCK_CTRL, 32'h100);
        apb(1'h1, thc_pkg::ADDR_IRQ_ENABLE, 32'h0C);
        check({31'h0, clkOe}, 32'h0);
        apb(1'h1, thc_pkg::ADDR_CONTROL, 32'h1);
        codecRun <= 1'h1;
        wait_irq();
        rdc(thc_pkg::ADDR_IRQ_STATUS, 32'h08);
        rdc(thc_pkg::ADDR_HOLDING, 32'hA3A2_A1A0);
        apb(1'h1, thc_pkg::ADDR_HOLDING, 32'h1122_3344);
        apb(1'h1, thc_pkg::ADDR_IRQ_ENABLE, 32'h0);
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        rdc(thc_pkg::ADDR_IRQ_STATUS, 32'h08);
        apb(1'h1, thc_pkg::ADDR_IRQ_CLEAR, 32'h0);
        apb(1'h1, thc_pkg::ADDR_IRQ_ENABLE, 32'h0C);
        rdc(thc_pkg::ADDR_IRQ_STATUS, 32'h0);
        wait_irq();
        rdc(thc_pkg::ADDR_IRQ_STATUS, 32'h04);
        apb(1'h1, thc_pkg::ADDR_HOLDING, 32'h5566_7788);
        apb(1'h1, thc_pkg::ADDR_IRQ_CLEAR, 32'h0);
        wait_irq();
        check({codec_u.txSlot[3], codec_u.txSlot[2], codec_u.txSlot[1], codec_u.txSlot[0]}, 32'h1122_3344);
        apb(1'h1, thc_pkg::ADDR_IRQ_CLEAR, 32'h0);
        wait_irq();
        check({codec_u.txSlot[3], codec_u.txSlot[2], codec_u.txSlot[1], codec_u.txSlot[0]}, 32'h5566_7788);
        tally_and_finish();
    end
endmodule // tb_top
bind thc_highway thc_highway_assertions chk_u (.clock, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .highwayClockOut, .highwayClockOe);

// ---- dv/thc_codec_model.sv ----
module thc_codec_model (
    input  wire logic run,
    input  wire logic txData,
    input  wire logic txOe,
    output logic      pinClk,
    output logic      fsync,
    output logic      rxData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] slotByte;
    logic [7:0] txSlot [4];
    // Odd start offset keeps the link phase unrelated to the bus clock
    initial begin
        pinClk = 1'h0;
        fsync = 1'h0;
        rxData = 1'h0;
        bitCnt = 8'hFF;
        #3;
        forever begin
            #40;
            if (run || pinClk) begin
                pinClk = ~pinClk;
            end
            // Last bit is taken at the next rise, before the block moves on
            if (pinClk) begin
                shiftIn = {shiftIn[6:0], txData};
                if (bitCnt[2:0] == 3'h7 && bitCnt[7:5] == 3'h0 && txOe) begin
                    txSlot[bitCnt[4:3]] = shiftIn;
                end
                bitCnt = bitCnt + 8'h01;
                slotByte = {4'hA, bitCnt[6:3]};
                fsync = (bitCnt == 8'hFF);
                rxData = slotByte[3'h7 - bitCnt[2:0]];
            end
        end
    end
endmodule // thc_codec_model

// ---- dv/thc_highway_assertions.sv ----
module thc_highway_assertions (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        highwayClockOut,
    input wire logic        highwayClockOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wrClk;
    logic       mapped;
    logic       dirReg;
    logic       enReg;
    logic       seenRise;
    logic [8:0] modReg;
    logic [8:0] gap;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    assign wrClk = psel && penable && pready && pwrite && paddr == thc_pkg::ADDR_CLOCK_CTRL;
    assign mapped = paddr >= thc_pkg::ADDR_CONTROL && paddr <= thc_pkg::ADDR_IRQ_CLEAR
        && paddr[1:0] == 2'h0 && !(paddr inside {16'hA804, 16'hA818});
    // Shadow of clock control, rebuilt from bus traffic only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dirReg <= 1'h0;
            enReg <= 1'h1;
            modReg <= 9'h002;
        end else if (wrClk) begin
            dirReg <= pwdata[9];
            enReg <= pwdata[8];
            modReg <= {1'h0, pwdata[7:0]} + 9'h002;
        end
    end
    // First rise after a config write is only a reference: the old count may linger
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gap <= 9'h000;
            seenRise <= 1'h0;
        end else if (wrClk) begin
            gap <= 9'h000;
            seenRise <= 1'h0;
        end else if ($rose(highwayClockOut)) begin
            gap <= 9'h001;
            seenRise <= 1'h1;
        end else if (gap != 9'h1FF) begin
            gap <= gap + 9'h001;
        end
    end
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_unmapped_error: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_clean: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access flagged");
    a_error_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_oe_follows_dir: assert property (wrClk |-> ##[1:2] (highwayClockOe == dirReg))
        else $error("clock pin direction wrong");
    a_clock_halted: assert property (!enReg [*4] |=> $stable(highwayClockOut))
        else $error("clock moves while disabled");
    a_divider_period: assert property (dirReg && enReg && seenRise && $rose(highwayClockOut) |-> gap == modReg)
        else $error("clock period wrong");
    a_irq_sticky: assert property (irq && !psel && !$past(psel) |=> irq)
        else $error("interrupt dropped without a write");
    c_unmapped: cover property (pready && pslverr);
    c_master_on: cover property (wrClk && pwdata[9] && pwdata[8]);
    c_irq_rise: cover property ($rose(irq));
endmodule // thc_highway_assertions

// ---- logic/thc_highway.sv ----
// The APB slave port was chosen for this implementation.
module thc_highway #(
    parameter int SLOT_W = 5
) (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     irq,
    input  wire logic                highwayClockIn,
    output logic                     highwayClockOut,
    output logic                     highwayClockOe,
    input  wire logic                frameSyncIn,
    output logic                     frameSyncOut,
    output logic                     frameSyncOe,
    input  wire logic                rxDataIn,
    output logic                     txDataOut,
    output logic                     txDataOe,
    output thc_pkg::thc_dma_req_t    dmaReq,
    input  wire logic                dmaAck,
    input  wire logic [31:0]         dmaRdata
);

    localparam int BW = thc_pkg::BYTE_W;

    // Returns a hit flag and the byte lane whose pointer entry names the slot
    function automatic logic [2:0] slotMatch(input logic [31:0] ptr, input logic [SLOT_W-1:0] slot);
        logic [2:0] res;
        res = 3'h0;
        for (int i = thc_pkg::BYTES_PER_WORD - 1; i >= 0; i--) begin
            if (ptr[i*BW +: SLOT_W] == slot) begin
                res = {1'b1, 2'(i)};
            end
        end
        return res;
    endfunction

    // Register state
    logic [31:0]               controlReg;
    logic [31:0]               clockCtrlReg;
    logic [31:0]               txBaseReg;
    logic [31:0]               rxBaseReg;
    logic [31:0]               txPtrReg [2];
    logic [31:0]               rxPtrReg [2];
    logic [31:0]               txHoldReg [2];
    logic [31:0]               rxHoldReg [2];
    logic [thc_pkg::IRQ_W-1:0] irqStatusReg;
    logic [thc_pkg::IRQ_W-1:0] irqEnableReg;
    logic                      lastHalfReg;

    logic busWrite;
    logic busSetup;
    assign busSetup = psel && !penable;
    assign busWrite = psel && penable && pready && pwrite;

    logic clkDir;
    logic clkEn;
    logic fsDir;
    logic running;
    assign clkDir  = clockCtrlReg[thc_pkg::CLK_DIR_BIT];
    assign clkEn   = clockCtrlReg[thc_pkg::CLK_EN_BIT];
    assign fsDir   = controlReg[thc_pkg::CTL_FS_DIR_BIT];
    assign running = controlReg[thc_pkg::CTL_RUN_BIT];

    // APB answer: ready in the first access cycle, data prepared at setup
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= thc_pkg::WORD_RESET;
        end else begin
            pready  <= busSetup;
            pslverr <= 1'b0;
            if (busSetup) begin
                prdata <= thc_pkg::WORD_RESET;
                case (paddr)
                    thc_pkg::ADDR_CONTROL:    prdata <= controlReg;
                    thc_pkg::ADDR_TX_PTR_A:   prdata <= txPtrReg[0];
                    thc_pkg::ADDR_TX_PTR_B:   prdata <= txPtrReg[1];
                    thc_pkg::ADDR_RX_PTR_A:   prdata <= rxPtrReg[0];
                    thc_pkg::ADDR_RX_PTR_B:   prdata <= rxPtrReg[1];
                    thc_pkg::ADDR_RX_BASE:    prdata <= thc_pkg::WORD_RESET;
                    thc_pkg::ADDR_TX_BASE:    prdata <= thc_pkg::WORD_RESET;
                    thc_pkg::ADDR_HOLDING:    prdata <= rxHoldReg[lastHalfReg];
                    thc_pkg::ADDR_CLOCK_CTRL: prdata <= clockCtrlReg;
                    thc_pkg::ADDR_IRQ_ENABLE: prdata <= 32'(irqEnableReg);
                    thc_pkg::ADDR_IRQ_STATUS: prdata <= 32'(irqStatusReg);
                    thc_pkg::ADDR_IRQ_CLEAR:  prdata <= thc_pkg::WORD_RESET;
                    default:                  pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            controlReg   <= thc_pkg::CONTROL_RESET;
            clockCtrlReg <= thc_pkg::CLOCK_CTRL_RESET;
            txBaseReg    <= thc_pkg::WORD_RESET;
            rxBaseReg    <= thc_pkg::WORD_RESET;
            txPtrReg[0]  <= thc_pkg::PTR_RESET;
            txPtrReg[1]  <= thc_pkg::PTR_RESET;
            rxPtrReg[0]  <= thc_pkg::PTR_RESET;
            rxPtrReg[1]  <= thc_pkg::PTR_RESET;
            irqEnableReg <= thc_pkg::IRQ_RESET;
        end else if (busWrite) begin
            case (paddr)
                thc_pkg::ADDR_CONTROL:    controlReg  <= pwdata;
                thc_pkg::ADDR_TX_PTR_A:   txPtrReg[0] <= pwdata;
                thc_pkg::ADDR_TX_PTR_B:   txPtrReg[1] <= pwdata;
                thc_pkg::ADDR_RX_PTR_A:   rxPtrReg[0] <= pwdata;
                thc_pkg::ADDR_RX_PTR_B:   rxPtrReg[1] <= pwdata;
                // Bases are kept apart so the buffers may be disjoint or shared
                thc_pkg::ADDR_RX_BASE:    rxBaseReg <= {pwdata[31:thc_pkg::BASE_LSB], 2'b00};
                thc_pkg::ADDR_TX_BASE:    txBaseReg <= {pwdata[31:thc_pkg::BASE_LSB], 2'b00};
                // Reserved clock bits stay zero
                thc_pkg::ADDR_CLOCK_CTRL: clockCtrlReg <= {22'h0, pwdata[9:0]};
                thc_pkg::ADDR_IRQ_ENABLE: irqEnableReg <= pwdata[thc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Pin synchronisers
    logic [1:0] clkSync;
    logic [1:0] fsSync;
    logic [1:0] rxdSync;
    logic       clkPrev;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clkSync <= 2'b00;
            fsSync  <= 2'b00;
            rxdSync <= 2'b00;
            clkPrev <= 1'b0;
        end else begin
            clkSync <= {clkSync[0], highwayClockIn};
            fsSync  <= {fsSync[0], frameSyncIn};
            rxdSync <= {rxdSync[0], rxDataIn};
            clkPrev <= clkSync[1];
        end
    end

    // Clock generator
    logic [thc_pkg::DIV_W-1:0] divCnt;
    logic [thc_pkg::DIV_W:0]   modulus;
    logic [thc_pkg::DIV_W:0]   halfMod;
    logic                      genRise;
    logic                      genFall;
    assign modulus = {1'b0, clockCtrlReg[thc_pkg::DIV_LSB +: thc_pkg::DIV_W]}
                     + thc_pkg::DIV_OFFSET;
    assign halfMod = modulus >> 1;
    assign genRise = {1'b0, divCnt} == modulus - 9'h001;
    assign genFall = {1'b0, divCnt} == halfMod - 9'h001;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divCnt          <= '0;
            highwayClockOut <= 1'b0;
            highwayClockOe  <= 1'b0;
        end else begin
            highwayClockOe <= clkDir;
            // Counter is held at zero with the enable off to save power
            if (clkEn && clkDir) begin
                divCnt          <= genRise ? '0 : divCnt + 1'b1;
                highwayClockOut <= genRise ? 1'b1 : (genFall ? 1'b0 : highwayClockOut);
            end else begin
                divCnt          <= '0;
                highwayClockOut <= 1'b0;
            end
        end
    end

    // One edge source for the framer, master or slave
    logic bitRise;
    logic bitFall;
    assign bitRise = clkEn && (clkDir ? genRise : (clkSync[1] && !clkPrev));
    assign bitFall = clkEn && (clkDir ? genFall : (!clkSync[1] && clkPrev));

    // Framer
    logic [2:0]        bitIdx;
    logic [SLOT_W-1:0] slotIdx;
    logic              halfSel;
    logic              fsLatch;
    logic              framed;
    logic [7:0]        txShift;
    logic [7:0]        rxShift;
    logic              fsSeen;
    logic [2:0]        nextBit;
    logic [SLOT_W-1:0] nextSlot;
    logic              nextHalf;
    logic              frameEnd;
    logic [2:0]        txHit;
    logic [2:0]        rxHit;
    logic [7:0]        rxByte;

    assign fsSeen   = fsDir ? frameSyncOut : fsSync[1];
    assign frameEnd = bitRise && fsLatch && framed && running;
    assign nextBit  = fsLatch ? 3'h0 : bitIdx + 3'h1;
    assign nextSlot = fsLatch ? '0 : ((bitIdx == 3'h7) ? slotIdx + 1'b1 : slotIdx);
    assign nextHalf = frameEnd ? !halfSel : halfSel;
    assign txHit    = slotMatch(txPtrReg[nextHalf], nextSlot);
    assign rxHit    = slotMatch(rxPtrReg[halfSel], slotIdx);
    assign rxByte   = {rxShift[6:0], rxdSync[1]};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bitIdx       <= 3'h0;
            slotIdx      <= '0;
            halfSel      <= 1'b0;
            fsLatch      <= 1'b0;
            framed       <= 1'b0;
            frameSyncOut <= 1'b0;
            frameSyncOe  <= 1'b0;
        end else begin
            frameSyncOe <= fsDir;
            if (!running) begin
                framed  <= 1'b0;
                fsLatch <= 1'b0;
                halfSel <= 1'b0;
            end else begin
                if (bitFall) begin
                    fsLatch <= fsSeen;
                end
                if (bitRise) begin
                    bitIdx  <= nextBit;
                    slotIdx <= nextSlot;
                    halfSel <= nextHalf;
                    if (fsLatch) begin
                        framed  <= 1'b1;
                        fsLatch <= 1'b0;
                    end
                    // Master sync marks the last bit of the frame
                    frameSyncOut <= fsDir && (nextSlot == '1) && (nextBit == 3'h7);
                end
            end
        end
    end

    // Transmit shifter, MSB first, driven only in owned slots
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txShift   <= 8'h00;
            txDataOut <= 1'b0;
            txDataOe  <= 1'b0;
        end else if (!running || !framed) begin
            txDataOe  <= 1'b0;
            txDataOut <= 1'b0;
        end else if (bitRise) begin
            if (nextBit == 3'h0) begin
                txShift   <= {txHoldReg[nextHalf][txHit[1:0]*BW +: 7], 1'b0};
                txDataOut <= txHoldReg[nextHalf][txHit[1:0]*BW + 7];
                txDataOe  <= txHit[2];
            end else begin
                txShift   <= {txShift[6:0], 1'b0};
                txDataOut <= txShift[7];
            end
        end
    end

    // Receive shifter and holding words
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxShift      <= 8'h00;
            rxHoldReg[0] <= thc_pkg::WORD_RESET;
            rxHoldReg[1] <= thc_pkg::WORD_RESET;
        end else if (bitFall && running && framed) begin
            rxShift <= rxByte;
            if (bitIdx == 3'h7 && rxHit[2]) begin
                rxHoldReg[halfSel][rxHit[1:0]*BW +: BW] <= rxByte;
            end
        end
    end

    // Buffer engine
    localparam int SIZE_BITS = thc_pkg::SIZE_W;
    thc_pkg::thc_dma_state_t dmaState;
    logic [SIZE_BITS-1:0]    txOff;
    logic [SIZE_BITS-1:0]    rxOff;
    logic [1:0]              txPend;
    logic [1:0]              rxPend;
    logic                    dmaHalf;
    logic [SIZE_BITS-1:0]    sizeWords;
    assign sizeWords = controlReg[thc_pkg::CTL_SIZE_LSB +: SIZE_BITS];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dmaState <= thc_pkg::THC_DMA_IDLE;
            dmaReq   <= '0;
            txOff    <= '0;
            rxOff    <= '0;
            txPend   <= 2'b00;
            rxPend   <= 2'b00;
            dmaHalf  <= 1'b0;
        end else begin
            // Pending sets win over the service clear in the same cycle
            if (frameEnd && controlReg[thc_pkg::CTL_TX_DMA_BIT]) begin
                txPend[halfSel] <= 1'b1;
            end
            if (frameEnd && controlReg[thc_pkg::CTL_RX_DMA_BIT]) begin
                rxPend[halfSel] <= 1'b1;
            end
            case (dmaState)
                thc_pkg::THC_DMA_IDLE: begin
                    if (|rxPend) begin
                        dmaHalf  <= rxPend[1] && !rxPend[0];
                        dmaReq   <= '{valid: 1'b1, write: 1'b1,
                                      addr: rxBaseReg + {18'h0, rxOff, 2'b00},
                                      wdata: rxHoldReg[rxPend[1] && !rxPend[0]]};
                        dmaState <= thc_pkg::THC_DMA_WRITE;
                    end else if (|txPend) begin
                        dmaHalf  <= txPend[1] && !txPend[0];
                        dmaReq   <= '{valid: 1'b1, write: 1'b0,
                                      addr: txBaseReg + {18'h0, txOff, 2'b00},
                                      wdata: thc_pkg::WORD_RESET};
                        dmaState <= thc_pkg::THC_DMA_READ;
                    end
                end
                thc_pkg::THC_DMA_WRITE: begin
                    if (dmaAck) begin
                        dmaReq   <= '0;
                        rxOff    <= (rxOff == sizeWords) ? '0 : rxOff + 1'b1;
                        dmaState <= thc_pkg::THC_DMA_IDLE;
                        if (!(frameEnd && halfSel == dmaHalf)) begin
                            rxPend[dmaHalf] <= 1'b0;
                        end
                    end
                end
                thc_pkg::THC_DMA_READ: begin
                    if (dmaAck) begin
                        dmaReq   <= '0;
                        txOff    <= (txOff == sizeWords) ? '0 : txOff + 1'b1;
                        dmaState <= thc_pkg::THC_DMA_IDLE;
                        if (!(frameEnd && halfSel == dmaHalf)) begin
                            txPend[dmaHalf] <= 1'b0;
                        end
                    end
                end
                default: dmaState <= thc_pkg::THC_DMA_IDLE;
            endcase
        end
    end

    // Transmit holding words: CPU write or buffer fetch
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txHoldReg[0] <= thc_pkg::WORD_RESET;
            txHoldReg[1] <= thc_pkg::WORD_RESET;
        end else begin
            if (busWrite && paddr == thc_pkg::ADDR_HOLDING) begin
                txHoldReg[lastHalfReg] <= pwdata;
            end
            if (dmaState == thc_pkg::THC_DMA_READ && dmaAck) begin
                txHoldReg[dmaHalf] <= dmaRdata;
            end
        end
    end

    // Interrupt status, enable and output
    logic [thc_pkg::IRQ_W-1:0] irqSet;
    logic [thc_pkg::IRQ_W-1:0] irqKeep;
    always_comb begin
        irqSet  = '0;
        irqKeep = '1;
        irqSet[thc_pkg::IRQ_HALF_A_BIT] = frameEnd && !halfSel;
        irqSet[thc_pkg::IRQ_HALF_B_BIT] = frameEnd && halfSel;
        if (busWrite && paddr == thc_pkg::ADDR_IRQ_CLEAR) begin
            irqKeep = pwdata[thc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqStatusReg <= thc_pkg::IRQ_RESET;
            lastHalfReg  <= 1'b0;
            irq          <= 1'b0;
        end else begin
            // Writing zero clears; a new event in that cycle still sets
            irqStatusReg <= (irqStatusReg & irqKeep) | irqSet;
            if (frameEnd) begin
                lastHalfReg <= halfSel;
            end
            irq <= |(irqStatusReg & irqEnableReg);
        end
    end

endmodule // thc_highway

// ---- logic/thc_pkg.sv ----
package thc_pkg;

    // Register byte addresses
    localparam logic [15:0] ADDR_CONTROL      = 16'hA800;
    localparam logic [15:0] ADDR_TX_PTR_A     = 16'hA808;
    localparam logic [15:0] ADDR_TX_PTR_B     = 16'hA80C;
    localparam logic [15:0] ADDR_RX_PTR_A     = 16'hA810;
    localparam logic [15:0] ADDR_RX_PTR_B     = 16'hA814;
    localparam logic [15:0] ADDR_RX_BASE      = 16'hA81C;
    localparam logic [15:0] ADDR_TX_BASE      = 16'hA820;
    localparam logic [15:0] ADDR_HOLDING      = 16'hA824;
    localparam logic [15:0] ADDR_CLOCK_CTRL   = 16'hA828;
    localparam logic [15:0] ADDR_IRQ_ENABLE   = 16'hA82C;
    localparam logic [15:0] ADDR_IRQ_STATUS   = 16'hA830;
    localparam logic [15:0] ADDR_IRQ_CLEAR    = 16'hA834;

    // Field positions
    localparam int CTL_RUN_BIT      = 0;
    localparam int CTL_TX_DMA_BIT   = 1;
    localparam int CTL_RX_DMA_BIT   = 2;
    localparam int CTL_FS_DIR_BIT   = 3;
    localparam int CTL_SIZE_LSB     = 4;
    localparam int SIZE_W           = 12;
    localparam int CLK_DIR_BIT      = 9;
    localparam int CLK_EN_BIT       = 8;
    localparam int DIV_LSB          = 0;
    localparam int DIV_W            = 8;
    localparam int BASE_LSB         = 2;
    localparam int IRQ_HALF_A_BIT   = 3;
    localparam int IRQ_HALF_B_BIT   = 2;
    localparam int IRQ_W            = 8;
    localparam int BYTE_W           = 8;
    localparam int BYTES_PER_WORD   = 4;

    // Reset values
    localparam logic [31:0] CONTROL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CLOCK_CTRL_RESET = 32'h0000_0100;
    localparam logic [31:0] WORD_RESET       = 32'h0000_0000;
    localparam logic [31:0] PTR_RESET        = 32'h0302_0100;
    localparam logic [IRQ_W-1:0] IRQ_RESET   = 8'h00;

    // Divider modulus is the field plus this offset
    localparam logic [DIV_W:0] DIV_OFFSET    = 9'h002;

    typedef enum {
        THC_DMA_IDLE,
        THC_DMA_READ,
        THC_DMA_WRITE
    } thc_dma_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } thc_dma_req_t;

endpackage
